// >>> design/vlpc_ctrl.sv
`timescale 1ns/100ps
module vlpc_ctrl (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [5:0]  cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rvalid,
   output logic             cp_running,
   output logic      [3:0]  event_dir,
   input  wire logic [31:0] chan_addr,
   output logic             chan_internal,
   output logic             chan_invalid,
   output logic             chan_virtual,
   input  wire logic [31:0] rc_index,
   output logic      [31:0] rc_addr,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [1:0]  rx_link,
   input  wire logic [15:0] rx_hdr,
   input  wire logic        rx_hdr_ok,
   input  wire logic [6:0]  rx_len,
   input  wire logic        rx_eom,
   input  wire logic [31:0] rx_room,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic      [31:0] out_cb_addr,
   output logic      [1:0]  out_kind,
   output logic      [1:0]  out_link,
   output logic      [31:0] out_count,
   output logic             err_serious,
   input  wire logic        tx_req,
   input  wire logic        tx_is_ack,
   input  wire logic        tx_acked,
   input  wire logic [31:0] tx_hcw,
   output logic             tx_ready,
   output logic             tx_done,
   output logic             tx_refused,
   output logic      [1:0]  tx_phys_link,
   output logic      [23:0] tx_hdr_bytes,
   output logic      [7:0]  tx_hdr_len,
   output logic             tx_hdr_long,
   output logic      [31:0] tx_hdr_addr,
   output logic             tx_list_word
);
   vlpc_pkg::vlpc_state_type state_q, state_d;
   logic [31:0] status_q;
   logic [3:0]  evmode_q;
   logic [31:0] memst_q, mininv_q, rcbase_q, hdrbase_q;
   logic [2:0]  lmode_q [4];
   logic [31:0] hofs_q [4];
   logic [31:0] hlow_q [4];
   logic [31:0] hup_q [4];
   logic [31:0] cfg_rdata_q;
   logic        cfg_rvalid_q;
   logic        err_q;

   // Command decode; a write with zero or several bits set does nothing
   wire cmd_wr     = cfg_wr && (cfg_addr == vlpc_pkg::OFS_CMD);
   wire cmd_onehot = (cfg_wdata[2:0] == 3'h1) || (cfg_wdata[2:0] == 3'h2)
                     || (cfg_wdata[2:0] == 3'h4);
   wire cmd_start  = cmd_wr && cmd_onehot && cfg_wdata[vlpc_pkg::CMD_START];
   wire cmd_stop   = cmd_wr && cmd_onehot && cfg_wdata[vlpc_pkg::CMD_STOP];
   wire cmd_reset  = cmd_wr && cmd_onehot && cfg_wdata[vlpc_pkg::CMD_RESET];
   wire cfg_clr    = sys_rst || cmd_reset;
   wire st_wr      = cfg_wr && (cfg_addr == vlpc_pkg::OFS_STATUS);

   // Run state: stop only blocks sending, receive keeps going
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         vlpc_pkg::HALTED:  if (cmd_start) state_d = vlpc_pkg::RUNNING;
         vlpc_pkg::RUNNING: if (cmd_stop) state_d = vlpc_pkg::STOPPED;
         vlpc_pkg::STOPPED: if (cmd_start) state_d = vlpc_pkg::RUNNING;
      endcase
      if (cmd_reset) state_d = vlpc_pkg::HALTED;
   end

   // Run state register
   always_ff @(posedge clk) begin
      if (sys_rst) state_q <= vlpc_pkg::HALTED;
      else state_q <= state_d;
   end

   assign cp_running = (state_q == vlpc_pkg::RUNNING);

   // Global configuration words
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         evmode_q  <= 4'h0;
         memst_q   <= vlpc_pkg::REG_RESET;
         mininv_q  <= vlpc_pkg::REG_RESET;
         rcbase_q  <= vlpc_pkg::REG_RESET;
         hdrbase_q <= vlpc_pkg::REG_RESET;
      end else if (cfg_wr) begin
         if (cfg_addr == vlpc_pkg::OFS_EVMODE) evmode_q <= cfg_wdata[3:0];
         if (cfg_addr == vlpc_pkg::OFS_MEMST) memst_q <= cfg_wdata;
         if (cfg_addr == vlpc_pkg::OFS_MININV) mininv_q <= cfg_wdata;
         if (cfg_addr == vlpc_pkg::OFS_RCBASE) rcbase_q <= cfg_wdata;
         if (cfg_addr == vlpc_pkg::OFS_HDRBASE) hdrbase_q <= cfg_wdata;
      end
   end

   // Per-link mode, offset and header window registers
   for (genvar l = 0; l < 4; l++) begin : g_link
      wire [5:0] li = 6'(l);
      always_ff @(posedge clk) begin
         if (cfg_clr) begin
            lmode_q[l] <= 3'h0;
            hofs_q[l]  <= vlpc_pkg::REG_RESET;
            hlow_q[l]  <= vlpc_pkg::REG_RESET;
            hup_q[l]   <= vlpc_pkg::REG_RESET;
         end else if (cfg_wr) begin
            if (cfg_addr == vlpc_pkg::OFS_LMODE + li) lmode_q[l] <= cfg_wdata[2:0];
            if (cfg_addr == vlpc_pkg::OFS_HOFS + li) hofs_q[l] <= cfg_wdata;
            if (cfg_addr == vlpc_pkg::OFS_HLOW + li) hlow_q[l] <= cfg_wdata;
            if (cfg_addr == vlpc_pkg::OFS_HUP + li) hup_q[l] <= cfg_wdata;
         end
      end
   end

   // Read mux; the command word and unmapped words read as zero
   wire [1:0] ra = cfg_addr[1:0];
   wire [31:0] rd_mux =
      (cfg_addr == vlpc_pkg::OFS_STATUS)  ? status_q :
      (cfg_addr == vlpc_pkg::OFS_EVMODE)  ? {28'h0, evmode_q} :
      (cfg_addr == vlpc_pkg::OFS_MEMST)   ? memst_q :
      (cfg_addr == vlpc_pkg::OFS_MININV)  ? mininv_q :
      (cfg_addr == vlpc_pkg::OFS_RCBASE)  ? rcbase_q :
      (cfg_addr == vlpc_pkg::OFS_HDRBASE) ? hdrbase_q :
      (cfg_addr[5:2] == vlpc_pkg::OFS_LMODE[5:2]) ? {29'h0, lmode_q[ra]} :
      (cfg_addr[5:2] == vlpc_pkg::OFS_HOFS[5:2])  ? hofs_q[ra] :
      (cfg_addr[5:2] == vlpc_pkg::OFS_HLOW[5:2])  ? hlow_q[ra] :
      (cfg_addr[5:2] == vlpc_pkg::OFS_HUP[5:2])   ? hup_q[ra] : 32'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_rdata_q  <= 32'h0;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rvalid_q <= cfg_rd;
         if (cfg_rd) cfg_rdata_q <= rd_mux;
      end
   end

   assign cfg_rdata  = cfg_rdata_q;
   assign cfg_rvalid = cfg_rvalid_q;
   assign event_dir  = evmode_q;

   // Channel address classes, compared as signed addresses
   assign chan_internal = $signed(chan_addr) >= $signed(memst_q);
   assign chan_invalid  = !chan_internal
                          && ($signed(chan_addr) >= $signed(mininv_q));
   assign chan_virtual  = !chan_internal && !chan_invalid;
   assign rc_addr = rcbase_q + (rc_index << vlpc_pkg::RC_STRIDE_SHIFT);

   // Receive classification; header width follows the link's length bit
   logic [1:0] buf_cnt_q;
   wire [2:0]  rx_mode = lmode_q[rx_link];
   wire [31:0] hval = rx_mode[vlpc_pkg::LM_HLEN] ? {16'h0, rx_hdr} : {24'h0, rx_hdr[7:0]};
   wire out_win  = (hval < hlow_q[rx_link]) || (hval > hup_q[rx_link]);
   wire hdr_bad  = !rx_hdr_ok || out_win;
   wire oversize = rx_len > vlpc_pkg::PKT_MAX;
   wire short_nt = !rx_eom && (rx_len != 7'h0) && (rx_len < vlpc_pkg::PKT_MAX);
   wire masked   = out_win && rx_hdr_ok && rx_mode[vlpc_pkg::LM_MASK];
   // Mask hides only window misses, never length errors
   wire hdr_err  = hdr_bad && !masked;
   wire rx_take  = rx_valid && rx_ready;
   wire rx_good  = rx_take && !hdr_bad && !oversize && !short_nt;
   wire rx_err   = rx_take && (hdr_err || oversize || short_nt);
   wire [1:0] err_code = hdr_err ? vlpc_pkg::ERR_HEADER :
                         oversize ? vlpc_pkg::ERR_OVERSIZE : vlpc_pkg::ERR_SHORT;
   wire [31:0] cb_addr = vlpc_pkg::CB_BASE
                         + ((hval - hofs_q[rx_link]) << vlpc_pkg::CB_SHIFT);
   wire [1:0] kind = rx_eom ? vlpc_pkg::PK_LAST :
                     (rx_len == 7'h0) ? vlpc_pkg::PK_ACK : vlpc_pkg::PK_FRAG;
   wire [31:0] cnt = ({25'h0, rx_len} > rx_room) ? vlpc_pkg::CNT_OVERRUN
                                                 : {25'h0, rx_len};
   // Accepting while halted would let packets in before the tables are set up
   assign rx_ready = (state_q != vlpc_pkg::HALTED) && (buf_cnt_q != 2'h2);

   // Error capture: first error wins, a status write clears, capture beats clear
   wire cap = rx_err && (!status_q[vlpc_pkg::ST_VALID] || st_wr);
   always_ff @(posedge clk) begin
      if (cfg_clr) status_q <= 32'h0;
      else if (cap) status_q <= {1'b1, 11'h0, rx_link, err_code, rx_hdr};
      else if (st_wr) status_q <= 32'h0;
   end

   // One-cycle serious error pulse
   always_ff @(posedge clk) begin
      if (sys_rst) err_q <= 1'b0;
      else err_q <= rx_err;
   end

   assign err_serious = err_q;

   // Two-entry buffer so a stalled consumer loses no descriptor
   // Entry: block address, kind, link, count
   // Count, not pointers, tells full from empty
   logic [67:0] buf_q [2];
   logic        wp_q, rp_q;
   wire push = rx_good;
   wire pop  = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         buf_cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= !wp_q;
         if (pop) rp_q <= !rp_q;
         buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Storage needs no reset; the count guards it
   always_ff @(posedge clk) begin
      if (push) buf_q[wp_q] <= {cb_addr, kind, rx_link, cnt};
   end

   assign out_valid   = (buf_cnt_q != 2'h0);
   assign out_cb_addr = buf_q[rp_q][67:36];
   assign out_kind    = buf_q[rp_q][35:34];
   assign out_link    = buf_q[rp_q][33:32];
   assign out_count   = buf_q[rp_q][31:0];

   // Send request decode from the header control word
   wire [1:0] ht    = tx_hcw[vlpc_pkg::HC_TYPE_LO +: 2];
   wire [1:0] tlink = tx_hcw[vlpc_pkg::HC_LINK_LO +: 2];
   wire tx_byte = lmode_q[tlink][vlpc_pkg::LM_BYTE];
   wire tx_ok = !tx_byte && (tx_is_ack ? tx_hcw[vlpc_pkg::HC_IN_OK]
                : (tx_hcw[vlpc_pkg::HC_OUT_OK] && tx_acked));
   wire [7:0] hlen = (ht == vlpc_pkg::HT_LONG) ? tx_hcw[23:16] :
                     (ht == vlpc_pkg::HT_ONE) ? 8'h01 :
                     (ht == vlpc_pkg::HT_TWO) ? 8'h02 : 8'h03;
   assign tx_ready = cp_running;
   wire tx_take = tx_req && tx_ready;

   logic        tx_done_q, tx_ref_q, tx_long_q, tx_list_q;
   logic [1:0]  tx_link_q;
   logic [23:0] tx_hb_q;
   logic [7:0]  tx_hl_q;
   logic [31:0] tx_ha_q;
   // Completion and refusal pulses
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         tx_done_q <= 1'b0;
         tx_ref_q  <= 1'b0;
      end else begin
         tx_done_q <= tx_take && tx_ok;
         tx_ref_q  <= tx_take && !tx_ok;
      end
   end

   // Per-packet header results, held until the next completed request; refused requests leave them unchanged
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         tx_link_q <= 2'h0;
         tx_hb_q   <= 24'h0;
         tx_hl_q   <= 8'h0;
         tx_long_q <= 1'b0;
         tx_ha_q   <= 32'h0;
         tx_list_q <= 1'b0;
      end else if (tx_take && tx_ok) begin
         tx_link_q <= tlink;
         tx_hb_q   <= tx_hcw[23:0];
         tx_hl_q   <= hlen;
         tx_long_q <= (ht == vlpc_pkg::HT_LONG);
         tx_ha_q   <= hdrbase_q + {16'h0, tx_hcw[15:0]};
         tx_list_q <= tx_is_ack;
      end
   end

   assign tx_done      = tx_done_q;
   assign tx_refused   = tx_ref_q;
   assign tx_phys_link = tx_link_q;
   assign tx_hdr_bytes = tx_hb_q;
   assign tx_hdr_len   = tx_hl_q;
   assign tx_hdr_long  = tx_long_q;
   assign tx_hdr_addr  = tx_ha_q;
   assign tx_list_word = tx_list_q;

   // Checks
   cmd_multi_a: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_wr && !cmd_onehot |=> state_q == $past(state_q))
      else $error("multi-bit command changed state");
   stop_keeps_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_q == vlpc_pkg::STOPPED |-> !tx_ready && (buf_cnt_q == 2'h2 || rx_ready))
      else $error("stopped state wrong handshakes");
   reset_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_reset |=> state_q == vlpc_pkg::HALTED && memst_q == 32'h0 && status_q == 32'h0)
      else $error("reset command did not clear");
   first_err_a: assert property (@(posedge clk) disable iff (sys_rst)
      status_q[vlpc_pkg::ST_VALID] && !st_wr && !cmd_reset |=> $stable(status_q))
      else $error("later error overwrote capture");
   st_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_wr && !rx_err && !cmd_reset |=> status_q == 32'h0)
      else $error("status write did not clear");
   cb_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      push && buf_cnt_q == 2'h0 |=> out_cb_addr[4:0] == 5'h0 && out_valid)
      else $error("control block address misaligned");
   serious_err_a: assert property (@(posedge clk) disable iff (sys_rst)
      rx_take && oversize |=> err_serious ##0 !out_valid || $past(buf_cnt_q) != 2'h0)
      else $error("oversize packet not flagged");
   overrun_cnt_a: assert property (@(posedge clk) disable iff (sys_rst)
      push && buf_cnt_q == 2'h0 && ({25'h0, rx_len} > rx_room)
      |=> out_count == vlpc_pkg::CNT_OVERRUN)
      else $error("overrun count not minus one");
   chan_class_a: assert property (@(posedge clk) disable iff (sys_rst)
      $onehot({chan_internal, chan_invalid, chan_virtual}))
      else $error("channel class not exclusive");
endmodule : vlpc_ctrl

// >>> design/vlpc_pkg.sv
package vlpc_pkg;
   // Configuration space word indices
   localparam logic [5:0] OFS_CMD     = 6'h00;
   localparam logic [5:0] OFS_STATUS  = 6'h01;
   localparam logic [5:0] OFS_EVMODE  = 6'h02;
   localparam logic [5:0] OFS_MEMST   = 6'h03;
   localparam logic [5:0] OFS_MININV  = 6'h04;
   localparam logic [5:0] OFS_RCBASE  = 6'h05;
   localparam logic [5:0] OFS_HDRBASE = 6'h06;
   localparam logic [5:0] OFS_LMODE   = 6'h08;
   localparam logic [5:0] OFS_HOFS    = 6'h0c;
   localparam logic [5:0] OFS_HLOW    = 6'h10;
   localparam logic [5:0] OFS_HUP     = 6'h14;
   // Command bits
   localparam int CMD_START = 0;
   localparam int CMD_STOP  = 1;
   localparam int CMD_RESET = 2;
   // Link mode bits
   localparam int LM_BYTE = 0;
   localparam int LM_MASK = 1;
   localparam int LM_HLEN = 2;
   // Header control word top byte fields
   localparam int HC_TYPE_LO = 24;
   localparam int HC_LINK_LO = 26;
   localparam int HC_IN_OK   = 28;
   localparam int HC_OUT_OK  = 29;
   localparam logic [1:0] HT_LONG = 2'h0;
   localparam logic [1:0] HT_ONE  = 2'h1;
   localparam logic [1:0] HT_TWO  = 2'h2;
   // Status layout
   localparam int ST_CODE_LO = 16;
   localparam int ST_LINK_LO = 18;
   localparam int ST_VALID   = 31;
   localparam logic [1:0] ERR_HEADER   = 2'h1;
   localparam logic [1:0] ERR_SHORT    = 2'h2;
   localparam logic [1:0] ERR_OVERSIZE = 2'h3;
   // Packet kinds
   localparam logic [1:0] PK_FRAG = 2'h0;
   localparam logic [1:0] PK_ACK  = 2'h1;
   localparam logic [1:0] PK_LAST = 2'h2;
   // Control block mapping and packet sizes
   localparam logic [31:0] CB_BASE  = 32'h80000040;
   localparam int          CB_SHIFT = 5;
   localparam logic [6:0]  PKT_MAX  = 7'h20;
   localparam logic [31:0] CNT_OVERRUN = 32'hffffffff;
   localparam logic [31:0] RC_STRIDE_SHIFT = 32'h00000003;
   localparam logic [31:0] REG_RESET = 32'h00000000;
   typedef enum logic [1:0] {HALTED, RUNNING, STOPPED} vlpc_state_type;
endpackage : vlpc_pkg

// >>> test/vlpc_peer_model.sv
`timescale 1ns/100ps
// Far link end: offers packet descriptors and sinks the buffered side
module vlpc_peer_model (
   input  wire logic        clk,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic      [1:0]  rx_link,
   output logic      [15:0] rx_hdr,
   output logic             rx_hdr_ok,
   output logic      [6:0]  rx_len,
   output logic             rx_eom,
   output logic      [31:0] rx_room,
   input  wire logic        out_valid,
   output logic             out_ready
);
   // Defined idle levels from time zero
   initial begin
      rx_valid = 1'b0;
      rx_link = 2'h0;
      rx_hdr = 16'h0;
      rx_hdr_ok = 1'b0;
      rx_len = 7'h0;
      rx_eom = 1'b0;
      rx_room = 32'h0;
      out_ready = 1'b1;
   end
   // One descriptor per packet; lengths stay within 32 unless a test asks for a bad one
   task automatic send(input logic [1:0] lk, input logic [15:0] hd, input logic ok,
                       input logic [6:0] ln, input logic message_end_token, input logic [31:0] room,
                       output logic taken);
      int   n;
      logic h;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_link <= lk;
      rx_hdr <= hd;
      rx_hdr_ok <= ok;
      rx_len <= ln;
      rx_eom <= message_end_token;
      rx_room <= room;
      n = 0;
      do begin
         @(negedge clk);
         h = rx_ready;
         @(posedge clk);
         n++;
      end while (!h && n < 40);
      taken = h;
      // Released lines flip so a stale value can never pass for a fresh one
      rx_valid <= 1'b0;
      rx_link <= ~lk;
      rx_hdr <= ~hd;
      rx_hdr_ok <= ~ok;
      rx_len <= ~ln;
      rx_eom <= ~message_end_token;
      rx_room <= ~room;
   endtask : send
   // Stall or release the sink side
   task automatic set_stall(input logic s);
      @(posedge clk);
      out_ready <= !s;
   endtask : set_stall
endmodule : vlpc_peer_model

// >>> test/tb_vlpc_ctrl.sv
`timescale 1ns/100ps
module tb_vlpc_ctrl;
   logic        clk, sys_rst, cfg_wr, cfg_rd, cfg_rvalid, cp_running, chan_internal, tk;
   logic        chan_invalid, chan_virtual, rx_valid, rx_ready, rx_hdr_ok, rx_eom, out_valid;
   logic        out_ready, err_serious, tx_req, tx_is_ack, tx_acked, tx_ready, tx_done;
   logic        tx_refused, tx_hdr_long, tx_list_word;
   logic [1:0]  rx_link, out_kind, out_link, tx_phys_link;
   logic [3:0]  event_dir;
   logic [5:0]  cfg_addr;
   logic [6:0]  rx_len;
   logic [7:0]  tx_hdr_len;
   logic [15:0] rx_hdr;
   logic [23:0] tx_hdr_bytes;
   logic [31:0] cfg_wdata, cfg_rdata, chan_addr, rc_index, rc_addr, rx_room, out_cb_addr, d;
   logic [31:0] out_count, tx_hcw, tx_hdr_addr;
   int          n_fail, tests_run;
   vlpc_ctrl vlpc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .cp_running(cp_running), .event_dir(event_dir), .chan_addr(chan_addr),
      .chan_internal(chan_internal), .chan_invalid(chan_invalid), .chan_virtual(chan_virtual),
      .rc_index(rc_index), .rc_addr(rc_addr), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_link(rx_link), .rx_hdr(rx_hdr), .rx_hdr_ok(rx_hdr_ok), .rx_len(rx_len),
      .rx_eom(rx_eom), .rx_room(rx_room), .out_valid(out_valid), .out_ready(out_ready),
      .out_cb_addr(out_cb_addr), .out_kind(out_kind), .out_link(out_link),
      .out_count(out_count), .err_serious(err_serious), .tx_req(tx_req), .tx_is_ack(tx_is_ack),
      .tx_acked(tx_acked), .tx_hcw(tx_hcw), .tx_ready(tx_ready), .tx_done(tx_done),
      .tx_refused(tx_refused), .tx_phys_link(tx_phys_link), .tx_hdr_bytes(tx_hdr_bytes),
      .tx_hdr_len(tx_hdr_len), .tx_hdr_long(tx_hdr_long), .tx_hdr_addr(tx_hdr_addr),
      .tx_list_word(tx_list_word));
   vlpc_peer_model vlpc_peer_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_link(rx_link), .rx_hdr(rx_hdr), .rx_hdr_ok(rx_hdr_ok), .rx_len(rx_len),
      .rx_eom(rx_eom), .rx_room(rx_room), .out_valid(out_valid), .out_ready(out_ready));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // Config accesses: strobe for one edge, read data looked at in its valid cycle
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= v;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk("cfg_rvalid", cfg_rvalid, 1'b1);
      v = cfg_rdata;
   endtask : rd
   task automatic pk(input logic [1:0] lk, input logic [15:0] hd, input logic ok,
                     input logic [6:0] ln, input logic message_end_token, input logic [31:0] room);
      vlpc_peer_model_inst.send(lk, hd, ok, ln, message_end_token, room, tk);
   endtask : pk
   // Waits for a descriptor, judges it, then lets the sink pop it
   task automatic take_out(input logic [31:0] cb, input logic [1:0] kd, input logic [1:0] lk,
                           input logic [31:0] ct);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (out_valid !== 1'b1 && n < 20);
      chk("out_cb_addr", out_cb_addr, cb);
      chk("out_kind", out_kind, kd);
      chk("out_link", out_link, lk);
      chk("out_count", out_count, ct);
      @(posedge clk);
   endtask : take_out
   task automatic tx(input logic [31:0] w, input logic a, input logic k, input logic ok);
      @(posedge clk);
      tx_req <= 1'b1;
      tx_hcw <= w;
      tx_is_ack <= a;
      tx_acked <= k;
      @(posedge clk);
      tx_req <= 1'b0;
      #1;
      chk("tx_done", tx_done, ok);
      chk("tx_refused", tx_refused, !ok);
   endtask : tx
   // Block address for every link set up with offset 2
   function automatic logic [31:0] cbx(input logic [31:0] h);
      return vlpc_pkg::CB_BASE + ((h - 32'h2) << vlpc_pkg::CB_SHIFT);
   endfunction : cbx
   function automatic logic [31:0] hcw(input logic oo, input logic io, input logic [1:0] lk,
                                      input logic [1:0] ty, input logic [23:0] lo);
      return {2'b00, oo, io, lk, ty, lo};
   endfunction : hcw
   task automatic t_reset();
      logic [5:0] ad[5] = '{vlpc_pkg::OFS_CMD, vlpc_pkg::OFS_STATUS, vlpc_pkg::OFS_EVMODE,
                           vlpc_pkg::OFS_LMODE, 6'h3f};
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], d);
         chk("reset_read", d, vlpc_pkg::REG_RESET);
      end
      chk("rx_ready", rx_ready, 1'b0);
      chk("tx_ready", tx_ready, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      wr(vlpc_pkg::OFS_EVMODE, 32'ha);
      rd(vlpc_pkg::OFS_EVMODE, d);
      chk("event_mode", d, 32'ha);
      chk("event_dir", event_dir, 4'ha);
      wr(vlpc_pkg::OFS_CMD, 32'h3);
      #1 chk("cp_running", cp_running, 1'b0);
      wr(vlpc_pkg::OFS_CMD, 32'h1);
      #1 chk("cp_running", cp_running, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(vlpc_pkg::OFS_HOFS + 6'(i), 32'h2);
         wr(vlpc_pkg::OFS_HLOW + 6'(i), 32'h2);
         wr(vlpc_pkg::OFS_HUP + 6'(i), 32'h200);
      end
      wr(vlpc_pkg::OFS_LMODE + 6'h1, 32'h4);
      rd(vlpc_pkg::OFS_LMODE + 6'h1, d);
      chk("link_mode", d, 32'h4);
      wr(vlpc_pkg::OFS_MEMST, 32'h80001000);
      wr(vlpc_pkg::OFS_MININV, 32'h80000800);
      wr(vlpc_pkg::OFS_RCBASE, 32'h80000400);
      $display("test regs done");
   endtask : t_regs
   task automatic t_chan();
      logic [31:0] ca[4] = '{32'h80001000, 32'h80000ffc, 32'h80000800, 32'h800007fc};
      logic [2:0]  ex[4] = '{3'h4, 3'h2, 3'h2, 3'h1};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         chan_addr <= ca[i];
         rc_index <= 32'(i);
         #1 chk("chan_class", {chan_internal, chan_invalid, chan_virtual}, ex[i]);
         chk("rc_addr", rc_addr, 32'h80000400 + 32'(i * 8));
      end
      $display("test chan done");
   endtask : t_chan
   task automatic t_rx();
      pk(2'h0, 16'hff05, 1'b1, 7'h20, 1'b0, 32'h64);
      take_out(cbx(32'h5), vlpc_pkg::PK_FRAG, 2'h0, 32'h20);
      pk(2'h1, 16'h0105, 1'b1, 7'h00, 1'b0, 32'h64);
      take_out(cbx(32'h105), vlpc_pkg::PK_ACK, 2'h1, 32'h0);
      pk(2'h2, 16'h0005, 1'b1, 7'h05, 1'b1, 32'h0a);
      take_out(cbx(32'h5), vlpc_pkg::PK_LAST, 2'h2, 32'h5);
      pk(2'h2, 16'h0005, 1'b1, 7'h05, 1'b1, 32'h03);
      take_out(cbx(32'h5), vlpc_pkg::PK_LAST, 2'h2, vlpc_pkg::CNT_OVERRUN);
      $display("test rx done");
   endtask : t_rx
   task automatic t_err();
      logic       ok[3] = '{1'b0, 1'b1, 1'b1};
      logic [6:0] ln[3] = '{7'h05, 7'h21, 7'h0a};
      logic       em[3] = '{1'b1, 1'b1, 1'b0};
      logic [1:0] cd[3] = '{vlpc_pkg::ERR_HEADER, vlpc_pkg::ERR_OVERSIZE, vlpc_pkg::ERR_SHORT};
      for (int i = 0; i < 3; i++) begin
         wr(vlpc_pkg::OFS_STATUS, 32'h5a);
         pk(2'h3, 16'h1234, ok[i], ln[i], em[i], 32'h64);
         #1 chk("err_serious", err_serious, 1'b1);
         rd(vlpc_pkg::OFS_STATUS, d);
         chk("status", d, {1'b1, 11'h0, 2'h3, cd[i], 16'h1234});
      end
      pk(2'h0, 16'h0001, 1'b1, 7'h05, 1'b1, 32'h64);
      #1 chk("err_serious", err_serious, 1'b1);
      rd(vlpc_pkg::OFS_STATUS, d);
      chk("status_kept", d, {1'b1, 11'h0, 2'h3, vlpc_pkg::ERR_SHORT, 16'h1234});
      wr(vlpc_pkg::OFS_STATUS, 32'hffffffff);
      rd(vlpc_pkg::OFS_STATUS, d);
      chk("status_clear", d, 32'h0);
      wr(vlpc_pkg::OFS_LMODE, 32'h2);
      pk(2'h0, 16'h0001, 1'b1, 7'h05, 1'b1, 32'h64);
      #1 chk("err_masked", err_serious, 1'b0);
      chk("dropped", out_valid, 1'b0);
      pk(2'h0, 16'h0001, 1'b1, 7'h21, 1'b1, 32'h64);
      #1 chk("mask_oversize", err_serious, 1'b1);
      rd(vlpc_pkg::OFS_STATUS, d);
      chk("status_oversize", d, {1'b1, 11'h0, 2'h0, vlpc_pkg::ERR_OVERSIZE, 16'h0001});
      wr(vlpc_pkg::OFS_LMODE, 32'h0);
      $display("test err done");
   endtask : t_err
   task automatic t_buf();
      vlpc_peer_model_inst.set_stall(1'b1);
      pk(2'h0, 16'h0005, 1'b1, 7'h20, 1'b0, 32'h64);
      pk(2'h0, 16'h0006, 1'b1, 7'h20, 1'b0, 32'h64);
      pk(2'h0, 16'h0007, 1'b1, 7'h20, 1'b0, 32'h64);
      chk("full_refused", tk, 1'b0);
      chk("held_cb", out_cb_addr, cbx(32'h5));
      vlpc_peer_model_inst.set_stall(1'b0);
      take_out(cbx(32'h5), vlpc_pkg::PK_FRAG, 2'h0, 32'h20);
      take_out(cbx(32'h6), vlpc_pkg::PK_FRAG, 2'h0, 32'h20);
      $display("test buf done");
   endtask : t_buf
   task automatic t_tx();
      wr(vlpc_pkg::OFS_HDRBASE, 32'h80000600);
      for (int t = 1; t < 4; t++) begin
         tx(hcw(1'b1, 1'b1, 2'h2, 2'(t), 24'h123456), 1'b0, 1'b1, 1'b1);
         chk("phys_link", tx_phys_link, 2'h2);
         chk("hdr_len", tx_hdr_len, 8'(t));
         chk("hdr_long", tx_hdr_long, 1'b0);
         chk("list_word", tx_list_word, 1'b0);
      end
      chk("hdr_bytes", tx_hdr_bytes, 24'h123456);
      tx(hcw(1'b1, 1'b1, 2'h1, 2'h0, 24'h080010), 1'b0, 1'b1, 1'b1);
      chk("hdr_long", tx_hdr_long, 1'b1);
      chk("hdr_addr", tx_hdr_addr, 32'h80000610);
      chk("hdr_len", tx_hdr_len, 8'h08);
      tx(hcw(1'b0, 1'b1, 2'h3, 2'h1, 24'h0), 1'b1, 1'b0, 1'b1);
      chk("list_word", tx_list_word, 1'b1);
      tx(hcw(1'b0, 1'b1, 2'h3, 2'h1, 24'h0), 1'b0, 1'b1, 1'b0);
      tx(hcw(1'b1, 1'b0, 2'h3, 2'h1, 24'h0), 1'b1, 1'b1, 1'b0);
      tx(hcw(1'b1, 1'b1, 2'h3, 2'h1, 24'h0), 1'b0, 1'b0, 1'b0);
      wr(vlpc_pkg::OFS_LMODE + 6'h2, 32'h1);
      tx(hcw(1'b1, 1'b1, 2'h2, 2'h1, 24'h0), 1'b0, 1'b1, 1'b0);
      $display("test tx done");
   endtask : t_tx
   task automatic t_cmd();
      wr(vlpc_pkg::OFS_CMD, 32'h2);
      #1 chk("cp_running", cp_running, 1'b0);
      chk("tx_ready", tx_ready, 1'b0);
      pk(2'h0, 16'h0005, 1'b1, 7'h03, 1'b1, 32'h64);
      take_out(cbx(32'h5), vlpc_pkg::PK_LAST, 2'h0, 32'h3);
      wr(vlpc_pkg::OFS_CMD, 32'h4);
      #1 chk("rx_ready", rx_ready, 1'b0);
      chk("event_dir", event_dir, 4'h0);
      rd(vlpc_pkg::OFS_HOFS, d);
      chk("hdr_offset", d, vlpc_pkg::REG_RESET);
      $display("test cmd done");
   endtask : t_cmd
   // Main sequence: defined inputs, three reset cycles, then the tests
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 6'h0;
      cfg_wdata = 32'h0;
      chan_addr = 32'h0;
      rc_index = 32'h0;
      tx_req = 1'b0;
      tx_is_ack = 1'b0;
      tx_acked = 1'b0;
      tx_hcw = 32'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_regs();
      t_chan();
      t_rx();
      t_err();
      t_buf();
      t_tx();
      t_cmd();
      give_verdict();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #500000;
      n_fail++;
      give_verdict();
   end
endmodule : tb_vlpc_ctrl
